//--- dpram_pkg.sv
// Package for the dual-port block RAM with selectable port clocking schemes.
// Assumes a single pclk domain; port clocks arrive as enable pulses from user logic.
package dpram_pkg;
    localparam int DATA_W = 72;
    localparam int LANE_W = 8;
    localparam int LANES = DATA_W / LANE_W;
    localparam int ADDR_W = 16;
    localparam int DEPTH = 64;
    localparam int IDX_W = 6;
    localparam int SP_SPLIT_BITS = 2048;
    // APB register byte addresses.
    localparam logic [11:0] MODE_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    // Clocking schemes selectable by software.
    typedef enum logic [1:0] {
        CLK_INDEPENDENT = 2'h0,
        CLK_IN_OUT = 2'h1,
        CLK_READ_WRITE = 2'h2,
        CLK_SINGLE = 2'h3
    } clk_mode_type;
    localparam int MODE_LSB = 0;
    localparam int OUTREG_A_BIT = 2;
    localparam int OUTREG_B_BIT = 3;
    localparam int SPLIT_BIT = 4;
endpackage : dpram_pkg

//--- ram_port_regs.sv
// One memory port's input and output register stages.
// Assumes clock enable pulses and clears already synchronised to pclk.
module ram_port_regs #(
    parameter int DW = 72,
    parameter int AW = 6,
    parameter int LN = 9
) (
    // Clock, reset, clears, enables and output bypass select.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_clr,
    input wire logic out_clr,
    input wire logic in_en,
    input wire logic out_en,
    input wire logic out_reg_on,
    // Request from fabric.
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wren,
    input wire logic [LN-1:0] lanes,
    // Registered request.
    output logic [AW-1:0] addr_q,
    output logic [DW-1:0] wdata_q,
    output logic wren_q,
    output logic [LN-1:0] lanes_q,
    // Read path.
    input wire logic [DW-1:0] array_rd,
    output logic [DW-1:0] rdata
);
    logic [AW-1:0] addr_next;
    logic [DW-1:0] wdata_next;
    logic wren_next;
    logic [LN-1:0] lanes_next;
    logic [DW-1:0] rd_reg;
    logic [DW-1:0] rd_next;

    // Input stage loads only on its enable pulse and otherwise holds.
    always_comb begin
        addr_next = addr_q;
        wdata_next = wdata_q;
        wren_next = wren_q;
        lanes_next = lanes_q;
        if (in_en) begin
            addr_next = addr;
            wdata_next = wdata;
            wren_next = wren;
            lanes_next = lanes;
        end
    end

    // Clears force zero on the next pclk edge, without waiting for an enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= '0;
            wdata_q <= '0;
            wren_q <= 1'b0;
            lanes_q <= '0;
        end else if (in_clr) begin
            addr_q <= '0;
            wdata_q <= '0;
            wren_q <= 1'b0;
            lanes_q <= '0;
        end else begin
            addr_q <= addr_next;
            wdata_q <= wdata_next;
            wren_q <= wren_next;
            lanes_q <= lanes_next;
        end
    end

    // Output stage; a bypass leaves the array word unregistered.
    always_comb begin
        rd_next = out_en ? array_rd : rd_reg;
        rdata = out_reg_on ? rd_reg : array_rd;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_reg <= '0;
        end else if (out_clr) begin
            rd_reg <= '0;
        end else begin
            rd_reg <= rd_next;
        end
    end
endmodule : ram_port_regs

//--- dpram_block.sv
// Dual-port block RAM with four clocking schemes, configured over APB.
// Assumes user logic supplies port clock enables, clears and requests synchronous to pclk.
// Operation
// - Independent mode: each port its own clock
// - Each port own enable and clear
// - Independent mode: every register has clear
// - In/out mode: input and output clocks differ
// - In/out mode: separate enables and clears
// - Simple dual-port read strobe has no clear
// - Write clock registers write data, address, strobe
// - Read clock registers output, address, strobe
// - Read/write clocks have own enables, clears
// - Single-port mode, optional split halves
// - Each port has 72-bit buses
// - One combined read/write enable per port
// - Writes gated by enable and lanes
// - Read output register may be bypassed
module dpram_block
    import dpram_pkg::*;
#(
    parameter int DW = dpram_pkg::DATA_W,
    parameter int AW = dpram_pkg::IDX_W
) (
    // APB slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port A clock-enable pulses and clears from fabric.
    input wire logic clk_a_en,
    input wire logic clk_a_out_en,
    input wire logic clken_a,
    input wire logic clken_a_out,
    input wire logic clr_a,
    input wire logic clr_a_out,
    // Port A request.
    input wire logic [AW-1:0] addr_a,
    input wire logic [DW-1:0] wdata_a,
    input wire logic rdwr_a,
    input wire logic [dpram_pkg::LANES-1:0] lanes_a,
    output logic [DW-1:0] rdata_a,
    // Port B clock-enable pulses and clears from fabric.
    input wire logic clk_b_en,
    input wire logic clk_b_out_en,
    input wire logic clken_b,
    input wire logic clken_b_out,
    input wire logic clr_b,
    input wire logic clr_b_out,
    // Port B request; in the simple dual-port mode (CLK_READ_WRITE) this is the read side.
    input wire logic [AW-1:0] addr_b,
    input wire logic [DW-1:0] wdata_b,
    input wire logic rdwr_b,
    input wire logic rden_b,
    input wire logic [dpram_pkg::LANES-1:0] lanes_b,
    output logic [DW-1:0] rdata_b
);
    import dpram_pkg::*;

    localparam int NW = 1 << AW;

    logic [31:0] mode_reg;
    logic [31:0] mode_next;
    logic [31:0] prdata_next;
    clk_mode_type mode;
    logic outreg_a;
    logic outreg_b;
    logic split;
    logic [DW-1:0] mem [NW];
    logic a_in_en;
    logic a_out_en;
    logic b_in_en;
    logic b_out_en;
    logic a_in_clr;
    logic a_out_clr;
    logic b_in_clr;
    logic b_out_clr;
    logic [AW-1:0] a_addr_q;
    logic [AW-1:0] b_addr_q;
    logic [DW-1:0] a_wdata_q;
    logic [DW-1:0] b_wdata_q;
    logic a_wren_q;
    logic b_wren_q;
    logic [LANES-1:0] a_lanes_q;
    logic [LANES-1:0] b_lanes_q;
    logic [DW-1:0] a_rd;
    logic [DW-1:0] b_rd;
    logic [DW-1:0] a_out;
    logic [DW-1:0] b_out;
    logic rden_reg;
    logic rden_next;
    logic [DW-1:0] rdata_a_reg;
    logic [DW-1:0] rdata_b_reg;
    logic [AW-1:0] b_index;
    logic simple_dp;
    logic b_writes;

    assign mode = clk_mode_type'(mode_reg[MODE_LSB +: 2]);
    assign outreg_a = mode_reg[OUTREG_A_BIT];
    assign outreg_b = mode_reg[OUTREG_B_BIT];
    assign split = mode_reg[SPLIT_BIT];
    assign simple_dp = (mode == CLK_READ_WRITE);

    // APB: zero-wait answer; the mode word is read/write, status is read-only.
    always_comb begin
        mode_next = mode_reg;
        prdata_next = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                MODE_OFF: prdata_next = mode_reg;
                STATUS_OFF: prdata_next = {29'h000_0000, rden_reg, b_wren_q, a_wren_q};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        if (psel && penable && pwrite && paddr == MODE_OFF) begin
            mode_next = pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= MODE_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            prdata <= prdata_next;
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != MODE_OFF && paddr != STATUS_OFF;
        end
    end

    // Clock routing per scheme; in single-port mode port B is idle unless split.
    always_comb begin
        a_in_en = clk_a_en && clken_a;
        a_out_en = clk_a_en && clken_a;
        b_in_en = clk_b_en && clken_b;
        b_out_en = clk_b_en && clken_b;
        a_in_clr = clr_a;
        a_out_clr = clr_a;
        b_in_clr = clr_b;
        b_out_clr = clr_b;
        case (mode)
            CLK_INDEPENDENT: begin
                a_out_en = clk_a_en && clken_a;
            end
            CLK_IN_OUT: begin
                a_out_en = clk_a_out_en && clken_a_out;
                b_out_en = clk_b_out_en && clken_b_out;
                a_out_clr = clr_a_out;
                b_out_clr = clr_b_out;
            end
            CLK_READ_WRITE: begin
                a_out_en = 1'b0;
                a_out_clr = clr_a;
                b_out_en = clk_b_en && clken_b;
            end
            CLK_SINGLE: begin
                b_in_en = split && clk_b_en && clken_b;
                b_out_en = split && clk_b_en && clken_b;
            end
            default: begin
                a_out_en = 1'b0;
            end
        endcase
    end

    ram_port_regs #(.DW(DW), .AW(AW), .LN(LANES)) port_a (
        .pclk(pclk),
        .presetn(presetn),
        .in_clr(a_in_clr),
        .out_clr(a_out_clr),
        .in_en(a_in_en),
        .out_en(a_out_en),
        .out_reg_on(outreg_a),
        .addr(addr_a),
        .wdata(wdata_a),
        .wren(rdwr_a),
        .lanes(lanes_a),
        .addr_q(a_addr_q),
        .wdata_q(a_wdata_q),
        .wren_q(a_wren_q),
        .lanes_q(a_lanes_q),
        .array_rd(a_rd),
        .rdata(a_out)
    );

    ram_port_regs #(.DW(DW), .AW(AW), .LN(LANES)) port_b (
        .pclk(pclk),
        .presetn(presetn),
        .in_clr(b_in_clr),
        .out_clr(b_out_clr),
        .in_en(b_in_en),
        .out_en(b_out_en),
        .out_reg_on(outreg_b),
        .addr(addr_b),
        .wdata(wdata_b),
        .wren(rdwr_b),
        .lanes(lanes_b),
        .addr_q(b_addr_q),
        .wdata_q(b_wdata_q),
        .wren_q(b_wren_q),
        .lanes_q(b_lanes_q),
        .array_rd(b_rd),
        .rdata(b_out)
    );

    // Read strobe for the simple dual-port read side carries no clear by design.
    always_comb begin
        rden_next = rden_reg;
        if (b_in_en) begin
            rden_next = rden_b;
        end
    end

    always_ff @(posedge pclk) begin
        rden_reg <= rden_next;
    end

    // Split single-port mode confines port B to the upper half of the array.
    assign b_index = (mode == CLK_SINGLE) ? {1'b1, b_addr_q[AW-2:0]} : b_addr_q;
    assign b_writes = b_wren_q && !simple_dp;

    // Asynchronous array reads; a loaded write waits in the input register until the next enabled edge.
    always_comb begin
        a_rd = mem[(mode == CLK_SINGLE && split) ? {1'b0, a_addr_q[AW-2:0]} : a_addr_q];
        b_rd = (simple_dp && !rden_reg) ? '0 : mem[b_index];
    end

    // Byte-lane write commit; a write happens only on the next enabled edge after an enabled load.
    always_ff @(posedge pclk) begin
        for (int l = 0; l < LANES; l++) begin
            if (a_wren_q && a_lanes_q[l] && a_in_en) begin
                mem[(mode == CLK_SINGLE && split) ? {1'b0, a_addr_q[AW-2:0]} : a_addr_q]
                    [l*LANE_W +: LANE_W] <= a_wdata_q[l*LANE_W +: LANE_W];
            end
            if (b_writes && b_lanes_q[l] && b_in_en) begin
                mem[b_index][l*LANE_W +: LANE_W] <= b_wdata_q[l*LANE_W +: LANE_W];
            end
        end
    end

    // Top outputs come straight from flops; the bypass path is sampled every cycle.
    // The output-side clear zeroes them as well, so a bypassed port shows no stale word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_a_reg <= '0;
            rdata_b_reg <= '0;
        end else begin
            rdata_a_reg <= a_out_clr ? '0 : a_out;
            rdata_b_reg <= b_out_clr ? '0 : b_out;
        end
    end

    assign rdata_a = rdata_a_reg;
    assign rdata_b = rdata_b_reg;
endmodule : dpram_block

//--- dpram_assertions.sv
// Checker for the register slave and port outputs of the block RAM.
// Assumes a bind to the top module ports, one pclk domain.
module dpram_assertions
    import dpram_pkg::*;
(
    // Watched ports.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic clken_a,
    input wire logic clken_a_out,
    input wire logic clken_b,
    input wire logic clr_a,
    input wire logic clr_a_out,
    input wire logic clr_b,
    input wire logic clr_b_out,
    input wire logic [71:0] rdata_a,
    input wire logic [71:0] rdata_b
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic mapped;
    // Only the two register words answer without an error.
    assign mapped = (paddr == MODE_OFF) || (paddr == STATUS_OFF);
    property p_ready_setup;
        psel && !penable |=> pready && penable;
    endproperty
    a_ready_setup: assert property (p_ready_setup) else $error("no ready");
    property p_ready_once;
        pready |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready held");
    property p_err_slot;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err_slot: assert property (p_err_slot) else $error("stray error");
    property p_err_unmapped;
        psel && !penable && !mapped |=> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("no error");
    property p_ok_mapped;
        psel && !penable && mapped |=> !pslverr;
    endproperty
    a_ok_mapped: assert property (p_ok_mapped) else $error("false error");
    // Two cycles of clear leave no stale word on the output.
    property p_clear_a;
        (clr_a && clr_a_out) [*2] |-> rdata_a == '0;
    endproperty
    a_clear_a: assert property (p_clear_a) else $error("a not cleared");
    property p_clear_b;
        (clr_b && clr_b_out) [*2] |-> rdata_b == '0;
    endproperty
    a_clear_b: assert property (p_clear_b) else $error("b not cleared");
    // Three quiet cycles let any earlier commit drain first.
    property p_hold_a;
        (!clken_a && !clken_a_out && !clken_b && !clr_a && !clr_a_out && !psel) [*3]
            |=> $stable(rdata_a);
    endproperty
    a_hold_a: assert property (p_hold_a) else $error("a moved");
endmodule : dpram_assertions

//--- fabric_port.sv
// Fabric logic that drives one memory port's request pins.
// Assumes the caller runs one operation at a time.
module fabric_port
    import dpram_pkg::*;
(
    // Clock.
    input wire logic pclk,
    // Request pins.
    output logic clk_en,
    output logic clken,
    output logic [IDX_W-1:0] addr,
    output logic [DATA_W-1:0] wdata,
    output logic rdwr,
    output logic rden,
    output logic [LANES-1:0] lanes
);
    // Lanes idle high so a plain write needs only rdwr.
    initial begin
        {clk_en, clken, rdwr, rden, addr, wdata} = '0;
        lanes = '1;
    end
    // One enabled edge; released data is inverted so stale values show.
    task automatic op(input logic [IDX_W-1:0] a, input logic [DATA_W-1:0] d,
            input logic w, input logic [LANES-1:0] ln, input logic ce);
        @(posedge pclk);
        clk_en <= 1'b1;
        clken <= ce;
        addr <= a;
        wdata <= d;
        rdwr <= w;
        rden <= ~w;
        lanes <= ln;
        @(posedge pclk);
        {clk_en, clken, rden} <= '0;
        addr <= ~a;
        wdata <= ~d;
    endtask : op
endmodule : fabric_port

//--- dpram_block_tb_top.sv
// Bench top for the block RAM: clocking modes, lanes, holds, clears.
// Assumes two fabric models drive the port requests.
module dpram_block_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dpram_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic clk_a_en, clken_a, rdwr_a, clk_b_en, clken_b, rdwr_b, rden_b;
    logic clk_a_out_en, clken_a_out, clr_a, clr_a_out;
    logic clk_b_out_en, clken_b_out, clr_b, clr_b_out;
    logic [IDX_W-1:0] addr_a, addr_b;
    logic [DATA_W-1:0] wdata_a, wdata_b, rdata_a, rdata_b;
    logic [LANES-1:0] lanes_a, lanes_b;
    int err_total, checks_done;
    dpram_block u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .clk_a_en, .clk_a_out_en, .clken_a, .clken_a_out,
        .clr_a, .clr_a_out, .addr_a, .wdata_a, .rdwr_a, .lanes_a, .rdata_a, .clk_b_en,
        .clk_b_out_en, .clken_b, .clken_b_out, .clr_b, .clr_b_out, .addr_b, .wdata_b,
        .rdwr_b, .rden_b, .lanes_b, .rdata_b);
    fabric_port fa (.pclk, .clk_en(clk_a_en), .clken(clken_a), .addr(addr_a),
        .wdata(wdata_a), .rdwr(rdwr_a), .rden(), .lanes(lanes_a));
    fabric_port fb (.pclk, .clk_en(clk_b_en), .clken(clken_b), .addr(addr_b),
        .wdata(wdata_b), .rdwr(rdwr_b), .rden(rden_b), .lanes(lanes_b));
    // Free-running clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic finish_test;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string name, input logic [71:0] exp, input logic [71:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
        end
    endtask : check
    // Register access; the request stands until ready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("apb ready", 1'b1, pready);
        if (n >= 20) finish_test();
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // A write is committed by the next enabled edge of port A.
    task automatic wr(input logic [5:0] a, input logic [71:0] d, input logic [8:0] ln,
            input logic ce);
        fa.op(a, d, 1'b1, ln, ce);
        fa.op(a, '0, 1'b0, '1, 1'b1);
    endtask : wr
    // The first enabled edge loads the address, the second the output register if used.
    task automatic rd(input logic sel_b, input logic [5:0] a, input logic [71:0] exp);
        int n;
        repeat (2) begin
            if (sel_b) begin
                fb.op(a, '0, 1'b0, '1, 1'b1);
            end else begin
                fa.op(a, '0, 1'b0, '1, 1'b1);
            end
        end
        for (n = 0; n < 12 && (sel_b ? rdata_b : rdata_a) !== exp; n++) @(posedge pclk);
        check("rdata", exp, sel_b ? rdata_b : rdata_a);
        if (n >= 12) finish_test();
    endtask : rd
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        apb(1'b0, MODE_OFF, '0, q, e);
        check("mode reset", MODE_RESET, q);
        apb(1'b1, MODE_OFF, 32'h0000_001D, q, e);
        apb(1'b0, MODE_OFF, '0, q, e);
        check("mode", 32'h0000_001D, q);
        apb(1'b0, 12'h008, '0, q, e);
        check("slverr", 1'b1, e);
    endtask : t_regs
    // Every mode, with and without the output register.
    task automatic t_modes;
        logic [31:0] q;
        logic e;
        logic [71:0] d;
        for (int m = 0; m < 8; m++) begin
            d = {9{8'(m + 1)}} ^ 72'h5A_0123_4567_89AB_CDEF;
            apb(1'b1, MODE_OFF, 32'(m % 4 + (m / 4) * 12), q, e);
            wr(6'(m), d, '1, 1'b1);
            rd(m % 4 != 3, 6'(m), d);
        end
    endtask : t_modes
    // Partial lanes, a write with its enable low, outputs frozen.
    task automatic t_lanes;
        logic [31:0] q;
        logic e;
        logic [71:0] p, n;
        p = 72'hC3_1111_2222_3333_4444;
        n = 72'h3C_AAAA_BBBB_CCCC_DDDD;
        apb(1'b1, MODE_OFF, '0, q, e);
        wr(6'h14, p, '1, 1'b1);
        wr(6'h14, n, 9'h101, 1'b1);
        rd(1'b1, 6'h14, {n[71:64], p[63:8], n[7:0]});
        wr(6'h14, p, '1, 1'b0);
        rd(1'b1, 6'h14, {n[71:64], p[63:8], n[7:0]});
        clken_a_out <= 1'b0;
        repeat (6) @(posedge pclk);
        clken_a_out <= 1'b1;
    endtask : t_lanes
    // Split single-port mode: each port owns its own half of the array.
    task automatic t_split;
        logic [31:0] q;
        logic e;
        apb(1'b1, MODE_OFF, 32'h0000_0013, q, e);
        wr(6'h05, {9{8'hA5}}, '1, 1'b1);
        fb.op(6'h05, {9{8'h5A}}, 1'b1, '1, 1'b1);
        fb.op(6'h05, '0, 1'b0, '1, 1'b1);
        rd(1'b0, 6'h05, {9{8'hA5}});
        rd(1'b1, 6'h05, {9{8'h5A}});
    endtask : t_split
    // Clears zero the outputs; the read strobe register keeps its value.
    task automatic t_clear;
        logic [31:0] q;
        logic e;
        {clr_a, clr_a_out, clr_b, clr_b_out} <= '1;
        repeat (3) @(posedge pclk);
        check("clear a", '0, rdata_a);
        check("clear b", '0, rdata_b);
        {clr_a, clr_a_out, clr_b, clr_b_out} <= '0;
        apb(1'b0, STATUS_OFF, '0, q, e);
        check("status", 32'h0000_0004, q);
    endtask : t_clear
    // In/out mode output stages run every cycle unless a scenario stops them.
    initial begin
        {err_total, checks_done} = '0;
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {clr_a, clr_a_out, clr_b, clr_b_out} = '0;
        {clk_a_out_en, clken_a_out, clk_b_out_en, clken_b_out} = '1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_modes();
        t_lanes();
        t_split();
        t_clear();
        finish_test();
    end
endmodule : dpram_block_tb_top
bind dpram_block dpram_assertions u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready,
    .pslverr, .clken_a, .clken_a_out, .clken_b, .clr_a, .clr_a_out, .clr_b, .clr_b_out,
    .rdata_a, .rdata_b);
